// >>> lrout_coil_drv.sv
`timescale 1ns/10ps
`default_nettype none
`include "lrout_defines.svh"

module lrout_coil_drv
   import lrout_pkg::*;
#(
   parameter int COIL_CYCLES = `LROUT_COIL_CYCLES
)
(
   input  wire logic i_ref_clk,
   input  wire logic i_rst_b,
   input  wire logic i_set_req,
   input  wire logic i_reset_req,
   output logic      o_set_coil,
   output logic      o_reset_coil,
   output logic      o_state
);

   localparam int CNT_W = $clog2(COIL_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(COIL_CYCLES - 1);

   lrout_coil_state_t coil_state_reg;
   lrout_coil_state_t coil_state_next;
   logic [CNT_W-1:0]  cnt_reg;
   logic [CNT_W-1:0]  cnt_next;
   logic              state_reg;
   logic              state_next;

   // A new request restarts the pulse, so the latest write always wins
   always_comb
   begin
      coil_state_next = coil_state_reg;
      cnt_next        = cnt_reg;
      state_next      = state_reg;
      case (coil_state_reg)
         LROUT_COIL_IDLE,
         LROUT_COIL_SET,
         LROUT_COIL_RESET:
         begin
            if (coil_state_reg != LROUT_COIL_IDLE)
            begin
               if (cnt_reg == CNT_LAST)
               begin
                  // Contact moves only once the coil pulse is complete
                  state_next      = (coil_state_reg == LROUT_COIL_SET);
                  coil_state_next = LROUT_COIL_IDLE;
                  cnt_next        = '0;
               end
               else
               begin
                  cnt_next = cnt_reg + CNT_W'(1);
               end
            end
            if (i_set_req)
            begin
               coil_state_next = LROUT_COIL_SET;
               cnt_next        = '0;
            end
            else if (i_reset_req)
            begin
               coil_state_next = LROUT_COIL_RESET;
               cnt_next        = '0;
            end
         end
         default:
         begin
            coil_state_next = LROUT_COIL_IDLE;
            cnt_next        = '0;
         end
      endcase
   end

   // State registers
   always_ff @(posedge i_ref_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         coil_state_reg <= LROUT_COIL_IDLE;
         cnt_reg        <= '0;
         state_reg      <= 1'b0;
      end
      else
      begin
         coil_state_reg <= coil_state_next;
         cnt_reg        <= cnt_next;
         state_reg      <= state_next;
      end
   end

   // One-hot codes: each coil drive is a state flop bit, so it cannot glitch
   assign o_set_coil   = coil_state_reg[1];
   assign o_reset_coil = coil_state_reg[2];
   assign o_state      = state_reg;

   property p_coil_excl;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      !(o_set_coil && o_reset_coil);
   endproperty
   a_coil_excl: assert property (p_coil_excl) else $error("both coils driven");

   property p_set_lands;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      $fell(o_set_coil) && !o_reset_coil |-> o_state;
   endproperty
   a_set_lands: assert property (p_set_lands) else $error("set pulse did not latch");

   property p_reset_lands;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      $fell(o_reset_coil) && !o_set_coil |-> !o_state;
   endproperty
   a_reset_lands: assert property (p_reset_lands) else $error("reset pulse did not clear");

endmodule : lrout_coil_drv
`default_nettype wire

// >>> lrout_defines.svh
`ifndef LROUT_DEFINES_SVH
`define LROUT_DEFINES_SVH

// Register width and byte offsets inside the I/O window
`define LROUT_DATA_W           16
`define LROUT_OFS_CTRL_LOW     16'h0000
`define LROUT_OFS_CTRL_HIGH    16'h0002
`define LROUT_OFS_READBACK     16'h0002
`define LROUT_OFS_ISO_INPUT    16'h0004
`define LROUT_OFS_CHG_DETECT   16'h0006
`define LROUT_OFS_IRQ          16'h0008
`define LROUT_OFS_BOARD_ID     16'h000A

// Field layout of a control word: channel n uses bits 2n and 2n+1
`define LROUT_PAIR_RESET_POS   0
`define LROUT_PAIR_SET_POS     1
`define LROUT_CH_PER_WORD      8
`define LROUT_CHANNELS         16
`define LROUT_ID_W             4

// Reset values
`define LROUT_STATE_RST        16'h0000
`define LROUT_RDATA_RST        16'h0000

// Coil drive time: relay operate and release time, in microseconds
`define LROUT_CLK_MHZ          100
`define LROUT_COIL_TIME_US     3000
`define LROUT_COIL_CYCLES      (`LROUT_COIL_TIME_US * `LROUT_CLK_MHZ)

`endif

// >>> lrout_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module lrout_host_model
(
   input  wire logic        i_ref_clk,
   output logic [15:0]      o_io_addr,
   output logic             o_io_wr,
   output logic             o_io_rd,
   output logic [15:0]      o_io_wdata,
   input  wire logic [15:0] i_io_rdata,
   input  wire logic        i_io_rd_ack
);

   // Idle bus; address and data later idle inverted so stale values never look valid
   initial
   begin
      o_io_addr  = 16'hFFFF;
      o_io_wr    = 1'b0;
      o_io_rd    = 1'b0;
      o_io_wdata = 16'hFFFF;
   end

   // One write cycle: strobe for exactly one clock, then release
   task automatic io_write(input logic [15:0] addr, input logic [15:0] data);
      @(negedge i_ref_clk);
      o_io_addr  = addr;
      o_io_wdata = data;
      o_io_wr    = 1'b1;
      @(negedge i_ref_clk);
      o_io_wr    = 1'b0;
      o_io_addr  = ~addr;
      o_io_wdata = ~data;
   endtask : io_write

   // One read cycle: answer is taken while the acknowledge stands, after the strobe edge
   task automatic io_read(input logic [15:0] addr, output logic [15:0] data,
                          output logic ack);
      @(negedge i_ref_clk);
      o_io_addr = addr;
      o_io_rd   = 1'b1;
      @(negedge i_ref_clk);
      ack  = i_io_rd_ack;
      data = i_io_rdata;
      o_io_rd   = 1'b0;
      o_io_addr = ~addr;
   endtask : io_read

endmodule : lrout_host_model
`default_nettype wire

// >>> lrout_pkg.sv
`default_nettype none
package lrout_pkg;

   // Coil driver state of one latching relay
   typedef enum logic [2:0]
   {
      LROUT_COIL_IDLE  = 3'b001,
      LROUT_COIL_SET   = 3'b010,
      LROUT_COIL_RESET = 3'b100
   } lrout_coil_state_t;

   // Action requested by one set/reset bit pair
   typedef enum logic [1:0]
   {
      LROUT_PAIR_HOLD  = 2'b00,
      LROUT_PAIR_RESET = 2'b01,
      LROUT_PAIR_SET   = 2'b10,
      LROUT_PAIR_BAD   = 2'b11
   } lrout_pair_t;

endpackage : lrout_pkg
`default_nettype wire

// >>> lrout_relay_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "lrout_defines.svh"

module lrout_relay_regs
   import lrout_pkg::*;
#(
   parameter int CHANNELS    = `LROUT_CHANNELS,
   parameter int COIL_CYCLES = `LROUT_COIL_CYCLES
)
(
   input  wire logic                     i_ref_clk,
   input  wire logic                     i_rst_b,
   input  wire logic [15:0]              i_io_base,
   input  wire logic [15:0]              i_io_addr,
   input  wire logic                     i_io_wr,
   input  wire logic                     i_io_rd,
   input  wire logic [`LROUT_DATA_W-1:0] i_io_wdata,
   output logic      [`LROUT_DATA_W-1:0] o_io_rdata,
   output logic                          o_io_rd_ack,
   input  wire logic [CHANNELS-1:0]      i_iso_input,
   input  wire logic [`LROUT_ID_W-1:0]   i_board_id_switch,
   output logic      [CHANNELS-1:0]      o_relay_set_coil,
   output logic      [CHANNELS-1:0]      o_relay_reset_coil,
   output logic      [CHANNELS-1:0]      o_relay_no_closed,
   output logic      [CHANNELS-1:0]      o_relay_nc_closed
);

   localparam int HALF = CHANNELS / 2;

   logic [`LROUT_DATA_W-1:0] rdata_reg;
   logic [`LROUT_DATA_W-1:0] rdata_next;
   logic                     ack_reg;
   logic                     ack_next;
   logic [CHANNELS-1:0]      set_req_reg;
   logic [CHANNELS-1:0]      set_req_next;
   logic [CHANNELS-1:0]      reset_req_reg;
   logic [CHANNELS-1:0]      reset_req_next;
   logic [CHANNELS-1:0]      no_reg;
   logic [CHANNELS-1:0]      no_next;
   logic [CHANNELS-1:0]      nc_reg;
   logic [CHANNELS-1:0]      nc_next;
   logic [CHANNELS-1:0]      state_vec;
   logic [15:0]              offset;
   logic                     wr_low;
   logic                     wr_high;
   logic [`LROUT_ID_W-1:0]   board_id;

   // Offset inside the window; the base comes from host enumeration
   function automatic logic [15:0] win_offset(input logic [15:0] addr,
                                              input logic [15:0] base);
      win_offset = addr - base;
   endfunction : win_offset

   // Action of one bit pair; both-ones maps to LROUT_PAIR_BAD, which the caller treats as hold
   function automatic lrout_pair_t pair_action(input logic [1:0] pair);
      case (pair)
         2'b01:   pair_action = LROUT_PAIR_RESET;
         2'b10:   pair_action = LROUT_PAIR_SET;
         2'b11:   pair_action = LROUT_PAIR_BAD;
         default: pair_action = LROUT_PAIR_HOLD;
      endcase
   endfunction : pair_action

   assign offset  = win_offset(i_io_addr, i_io_base);
   // Odd offsets never match, since only word accesses exist
   assign wr_low  = i_io_wr && (offset == `LROUT_OFS_CTRL_LOW);
   assign wr_high = i_io_wr && (offset == `LROUT_OFS_CTRL_HIGH);
   // Switch on reads as zero, so all switches on give identifier 15
   assign board_id = ~i_board_id_switch;

   // Split a control write into per-channel set and reset requests
   always_comb
   begin
      set_req_next   = '0;
      reset_req_next = '0;
      for (int n = 0; n < HALF; n++)
      begin
         // Reset bit at 2n, set bit at 2n+1
         case (pair_action(i_io_wdata[2*n +: 2]))
            LROUT_PAIR_RESET:
            begin
               reset_req_next[n]      = wr_low;
               reset_req_next[n+HALF] = wr_high;
            end
            LROUT_PAIR_SET:
            begin
               set_req_next[n]        = wr_low;
               set_req_next[n+HALF]   = wr_high;
            end
            default:
            begin
               // Hold and the forbidden pair leave the relay alone
               set_req_next[n]        = 1'b0;
               reset_req_next[n]      = 1'b0;
            end
         endcase
      end
   end

   // Request pulses last one cycle
   always_ff @(posedge i_ref_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         set_req_reg   <= '0;
         reset_req_reg <= '0;
      end
      else
      begin
         set_req_reg   <= set_req_next;
         reset_req_reg <= reset_req_next;
      end
   end

   // One coil driver per relay, each with its own latched state
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++)
      begin : g_relay
         lrout_coil_drv #(
            .COIL_CYCLES (COIL_CYCLES)
         ) u_coil (
            .i_ref_clk    (i_ref_clk),
            .i_rst_b      (i_rst_b),
            .i_set_req    (set_req_reg[g]),
            .i_reset_req  (reset_req_reg[g]),
            .o_set_coil   (o_relay_set_coil[g]),
            .o_reset_coil (o_relay_reset_coil[g]),
            .o_state      (state_vec[g])
         );
      end
   endgenerate

   // Contact view: reset opens NO and closes NC to common
   always_comb
   begin
      no_next = state_vec;
      nc_next = ~state_vec;
   end

   // Contact outputs registered so they come from flops
   always_ff @(posedge i_ref_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         no_reg <= `LROUT_STATE_RST;
         nc_reg <= ~`LROUT_STATE_RST;
      end
      else
      begin
         no_reg <= no_next;
         nc_reg <= nc_next;
      end
   end

   // Read mux; data stand from the cycle after the strobe until next read
   always_comb
   begin
      rdata_next = rdata_reg;
      ack_next   = i_io_rd;
      if (i_io_rd)
      begin
         case (offset)
            `LROUT_OFS_READBACK:
               rdata_next = `LROUT_DATA_W'(state_vec);
            `LROUT_OFS_ISO_INPUT:
               rdata_next = `LROUT_DATA_W'(i_iso_input);
            `LROUT_OFS_BOARD_ID:
               // Zero fill by concatenation; a widening cast would invert the upper bits too
               rdata_next = {{(`LROUT_DATA_W-`LROUT_ID_W){1'b0}}, board_id};
            default:
               // Change detect, interrupt and empty slots read zero
               rdata_next = '0;
         endcase
      end
   end

   // Read data register
   always_ff @(posedge i_ref_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rdata_reg <= `LROUT_RDATA_RST;
         ack_reg   <= 1'b0;
      end
      else
      begin
         rdata_reg <= rdata_next;
         ack_reg   <= ack_next;
      end
   end

   assign o_io_rdata         = rdata_reg;
   assign o_io_rd_ack        = ack_reg;
   assign o_relay_no_closed  = no_reg;
   assign o_relay_nc_closed  = nc_reg;

   // Per-channel checks on the write path
   generate
      for (g = 0; g < HALF; g++)
      begin : g_chk
         property p_low_set;
            @(posedge i_ref_clk) disable iff (!i_rst_b)
            wr_low && i_io_wdata[2*g +: 2] == 2'b10
               |=> set_req_reg[g] ##1 o_relay_set_coil[g];
         endproperty
         a_low_set: assert property (p_low_set) else $error("low set not driven");

         property p_high_reset;
            @(posedge i_ref_clk) disable iff (!i_rst_b)
            wr_high && i_io_wdata[2*g +: 2] == 2'b01
               |=> reset_req_reg[g+HALF] ##1 o_relay_reset_coil[g+HALF];
         endproperty
         a_high_reset: assert property (p_high_reset) else $error("high reset lost");

         property p_pair_hold;
            @(posedge i_ref_clk) disable iff (!i_rst_b)
            i_io_wr && i_io_wdata[2*g +: 2] == 2'b00
               |=> !set_req_reg[g] && !reset_req_reg[g]
                   && !set_req_reg[g+HALF] && !reset_req_reg[g+HALF];
         endproperty
         a_pair_hold: assert property (p_pair_hold) else $error("idle pair moved relay");

         property p_pair_pos;
            @(posedge i_ref_clk) disable iff (!i_rst_b)
            wr_low && i_io_wdata[2*g +: 2] == 2'b01
               |=> reset_req_reg[g] && !set_req_reg[g];
         endproperty
         a_pair_pos: assert property (p_pair_pos) else $error("bit pair misplaced");

         property p_high_set;
            @(posedge i_ref_clk) disable iff (!i_rst_b)
            wr_high && i_io_wdata[2*g +: 2] == 2'b10
               |=> set_req_reg[g+HALF] ##1 o_relay_set_coil[g+HALF];
         endproperty
         a_high_set: assert property (p_high_set) else $error("high set not driven");

         property p_set_cause;
            @(posedge i_ref_clk) disable iff (!i_rst_b)
            $rose(o_relay_set_coil[g]) |-> $past(set_req_reg[g]);
         endproperty
         a_set_cause: assert property (p_set_cause) else $error("unrequested set coil");
      end
   endgenerate

   property p_rd_readback;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_io_rd && offset == `LROUT_OFS_READBACK
         |=> o_io_rd_ack && o_io_rdata == $past(state_vec);
   endproperty
   a_rd_readback: assert property (p_rd_readback) else $error("bad readback");

   property p_rd_iso;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_io_rd && offset == `LROUT_OFS_ISO_INPUT
         |=> o_io_rdata == $past(i_iso_input);
   endproperty
   a_rd_iso: assert property (p_rd_iso) else $error("bad input read");

   property p_rd_id;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_io_rd && offset == `LROUT_OFS_BOARD_ID
         |=> o_io_rdata[3:0] == ~$past(i_board_id_switch)
             && o_io_rdata[15:4] == 12'h000;
   endproperty
   a_rd_id: assert property (p_rd_id) else $error("bad board id");

   property p_rd_unmapped;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_io_rd && offset != `LROUT_OFS_READBACK
         && offset != `LROUT_OFS_ISO_INPUT && offset != `LROUT_OFS_BOARD_ID
         |=> o_io_rdata == 16'h0000;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

   property p_wr_ignored;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_io_wr && offset != `LROUT_OFS_CTRL_LOW && offset != `LROUT_OFS_CTRL_HIGH
         |=> set_req_reg == '0 && reset_req_reg == '0;
   endproperty
   a_wr_ignored: assert property (p_wr_ignored) else $error("stray write acted");

   property p_contacts;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      o_relay_nc_closed == ~o_relay_no_closed;
   endproperty
   a_contacts: assert property (p_contacts) else $error("NO and NC agree");

   property p_contact_follow;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      ##1 o_relay_no_closed == $past(state_vec);
   endproperty
   a_contact_follow: assert property (p_contact_follow) else $error("contact lags");

   // Read handshake: the acknowledge echoes the strobe, and data only move on a read
   property p_ack_pulse;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      ##1 o_io_rd_ack == $past(i_io_rd);
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack does not echo strobe");

   property p_rdata_hold;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      !i_io_rd |=> $stable(o_io_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

   // A control word only ever reaches its own half of the relays
   property p_low_only;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      wr_low |=> set_req_reg[CHANNELS-1:HALF] == '0 && reset_req_reg[CHANNELS-1:HALF] == '0;
   endproperty
   a_low_only: assert property (p_low_only) else $error("low word hit high relays");

   property p_high_only;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      wr_high |=> set_req_reg[HALF-1:0] == '0 && reset_req_reg[HALF-1:0] == '0;
   endproperty
   a_high_only: assert property (p_high_only) else $error("high word hit low relays");

endmodule : lrout_relay_regs
`default_nettype wire

// >>> test_latching_relay_output_regs.sv
`timescale 1ns/10ps
`default_nettype none

module test_latching_relay_output_regs;
   localparam int          COIL_CYC = 8;

   logic        i_ref_clk;
   logic        i_rst_b;
   logic [15:0] io_base;
   logic [15:0] io_addr;
   logic        io_wr;
   logic        io_rd;
   logic [15:0] io_wdata;
   logic [15:0] io_rdata;
   logic        io_rd_ack;
   logic [15:0] iso_input;
   logic [3:0]  id_switch;
   logic [15:0] set_coil;
   logic [15:0] reset_coil;
   logic [15:0] no_closed;
   logic [15:0] nc_closed;
   int          failures;
   int          n_checks;
   int          n_cycles;

   lrout_host_model i_host (
      .i_ref_clk   (i_ref_clk),
      .o_io_addr   (io_addr),
      .o_io_wr     (io_wr),
      .o_io_rd     (io_rd),
      .o_io_wdata  (io_wdata),
      .i_io_rdata  (io_rdata),
      .i_io_rd_ack (io_rd_ack)
   );

   lrout_relay_regs #(.COIL_CYCLES(COIL_CYC)) i_dut (
      .i_ref_clk          (i_ref_clk),
      .i_rst_b            (i_rst_b),
      .i_io_base          (io_base),
      .i_io_addr          (io_addr),
      .i_io_wr            (io_wr),
      .i_io_rd            (io_rd),
      .i_io_wdata         (io_wdata),
      .o_io_rdata         (io_rdata),
      .o_io_rd_ack        (io_rd_ack),
      .i_iso_input        (iso_input),
      .i_board_id_switch  (id_switch),
      .o_relay_set_coil   (set_coil),
      .o_relay_reset_coil (reset_coil),
      .o_relay_no_closed  (no_closed),
      .o_relay_nc_closed  (nc_closed)
   );

   // 100 MHz clock
   initial i_ref_clk = 1'b0;
   always #5 i_ref_clk = ~i_ref_clk;

   // Whole run needs about 230 cycles; the ceiling leaves a wide margin
   always @(posedge i_ref_clk)
   begin
      n_cycles++;
      if (n_cycles == 5000)
      begin
         failures++;
         $display("Error at %0t: run did not finish in time", $time);
         give_verdict();
      end
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic rd(input logic [15:0] ofs, input logic [15:0] exp, input string what);
      logic [15:0] d;
      logic        ack;
      i_host.io_read(io_base + ofs, d, ack);
      check({15'h0000, ack}, 16'h0001, "read ack");
      check(d, exp, what);
   endtask : rd

   // Write, then watch the coils long enough to see the whole pulse and its end
   task automatic wr_coil(input logic [15:0] ofs, input logic [15:0] wd,
                          input logic [15:0] set_m, input logic [15:0] rst_m,
                          input int exp_hit);
      int hit;
      int bad;
      hit = 0;
      bad = 0;
      i_host.io_write(io_base + ofs, wd);
      repeat (COIL_CYC + 4)
      begin
         @(negedge i_ref_clk);
         if (set_coil === set_m && reset_coil === rst_m)
            hit++;
         else if (set_coil !== 16'h0000 || reset_coil !== 16'h0000)
            bad++;
      end
      check(16'(hit), 16'(exp_hit), "coil pulse cycles");
      check(16'(bad), 16'h0000, "stray coil drive");
   endtask : wr_coil

   // Readback register and contact outputs agree on the relay states
   task automatic chk_state(input logic [15:0] exp);
      rd(16'h0002, exp, "relay readback");
      check(no_closed, exp, "normally open contacts");
      check(nc_closed, ~exp, "normally closed contacts");
   endtask : chk_state

   task automatic t_reset();
      check(set_coil, 16'h0000, "set coils after reset");
      check(reset_coil, 16'h0000, "reset coils after reset");
      check(io_rdata, 16'h0000, "read data after reset");
      chk_state(16'h0000);
      $display("Test reset done");
   endtask : t_reset

   task automatic t_set_words();
      wr_coil(16'h0000, 16'h2222, 16'h0055, 16'h0000, COIL_CYC);
      chk_state(16'h0055);
      wr_coil(16'h0002, 16'hAAAA, 16'hFF00, 16'h0000, COIL_CYC);
      chk_state(16'hFF55);
      $display("Test set words done");
   endtask : t_set_words

   task automatic t_reset_pairs();
      wr_coil(16'h0000, 16'h8001, 16'h0080, 16'h0001, COIL_CYC);
      chk_state(16'hFFD4);
      wr_coil(16'h0002, 16'h4000, 16'h0000, 16'h8000, COIL_CYC);
      chk_state(16'h7FD4);
      $display("Test reset pairs done");
   endtask : t_reset_pairs

   // Writes to read-only, unbuilt and out-of-window offsets change nothing
   task automatic t_ignored_writes();
      logic [15:0] ofs [5];
      ofs = '{16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'hFD00};
      foreach (ofs[i])
         wr_coil(ofs[i], 16'h5555, 16'h0000, 16'h0000, COIL_CYC + 4);
      chk_state(16'h7FD4);
      $display("Test ignored writes done");
   endtask : t_ignored_writes

   // A write while a coil still pulses restarts it; the cut set pulse never latches
   task automatic t_restart();
      i_host.io_write(io_base, 16'h0002);
      wr_coil(16'h0000, 16'h0001, 16'h0000, 16'h0001, COIL_CYC);
      chk_state(16'h7FD4);
      $display("Test restart done");
   endtask : t_restart

   // Moving the window follows the new base; the old addresses go dead
   task automatic t_rebase();
      io_base = 16'hC000;
      chk_state(16'h7FD4);
      rd(16'h4302, 16'h0000, "old window");
      io_base = 16'h0300;
      $display("Test rebase done");
   endtask : t_rebase

   task automatic t_iso_inputs();
      iso_input = 16'hA5C3;
      rd(16'h0004, 16'hA5C3, "isolated inputs");
      iso_input = 16'h5A3C;
      rd(16'h0004, 16'h5A3C, "isolated inputs");
      $display("Test isolated inputs done");
   endtask : t_iso_inputs

   // Every switch setting gives its inverse as identifier
   task automatic t_board_id();
      for (int s = 0; s < 16; s++)
      begin
         id_switch = 4'(s);
         rd(16'h000A, {12'h000, ~4'(s)}, "board id");
      end
      $display("Test board id done");
   endtask : t_board_id

   // Unmapped reads return zero even after a nonzero read
   task automatic t_unmapped_reads();
      logic [15:0] ofs [5];
      ofs = '{16'h0000, 16'h0006, 16'h0008, 16'h000C, 16'hFD02};
      foreach (ofs[i])
      begin
         rd(16'h0004, 16'h5A3C, "isolated inputs");
         rd(ofs[i], 16'h0000, "unmapped read");
      end
      $display("Test unmapped reads done");
   endtask : t_unmapped_reads

   task automatic give_verdict();
      $display("Checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   // Main sequence
   initial
   begin
      failures  = 0;
      n_checks  = 0;
      n_cycles  = 0;
      io_base   = 16'h0300;
      i_rst_b   = 1'b0;
      iso_input = 16'h0000;
      id_switch = 4'h0;
      repeat (10) @(negedge i_ref_clk);
      i_rst_b = 1'b1;
      t_reset();
      t_set_words();
      t_reset_pairs();
      t_ignored_writes();
      t_restart();
      t_rebase();
      t_iso_inputs();
      t_board_id();
      t_unmapped_reads();
      give_verdict();
   end

endmodule : test_latching_relay_output_regs
`default_nettype wire
